/* File: sac_regs.svh */
// Constants for the serial converter host controller
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// Clock and timing figures
`define SAC_CLK_PERIOD_PS 5000
`define SAC_WAKE_NS 2500
`define SAC_TCS_NS 60
`define SAC_CONV_MAX_NS 140000
`define SAC_EXT_FMAX_KHZ 2170
`define SAC_EXT_FMIN_KHZ 100
`define SAC_INT_FMAX_KHZ 5000
`define SAC_CEIL_CYC(ns) ((((ns) * 1000) + `SAC_CLK_PERIOD_PS - 1) / `SAC_CLK_PERIOD_PS)
`define SAC_FLOOR_CYC(ns) (((ns) * 1000) / `SAC_CLK_PERIOD_PS)
`define SAC_HALF_CEIL(k) ((1000000000 + 2 * (k) * `SAC_CLK_PERIOD_PS - 1) / (2 * (k) * `SAC_CLK_PERIOD_PS))
`define SAC_HALF_FLOOR(k) (1000000000 / (2 * (k) * `SAC_CLK_PERIOD_PS))
`define SAC_BYTE_GAP_CYC 8

// Frame layout
`define SAC_FRAME_BITS 16
`define SAC_BYTE_BITS 8
`define SAC_CNT_W 5
`define SAC_LEAD_MSB 15
`define SAC_LEAD_LSB 13
`define SAC_LEAD_ONES 3'h7
`define SAC_CHANNEL_ID_BIT_POS 12

// Register map
`define SAC_ADDR_CTRL 8'h00
`define SAC_ADDR_STATUS 8'h04
`define SAC_ADDR_RESULT 8'h08
`define SAC_ADDR_DIV 8'h0c
`define SAC_CTRL_START 0
`define SAC_CTRL_INT 1
`define SAC_CTRL_BYTE 2
`define SAC_CTRL_REPEAT 3
`define SAC_CTRL_ABORT 4
`define SAC_ST_BUSY 0
`define SAC_ST_DONE 1
`define SAC_ST_TMO 2
`define SAC_ST_MISM 3
`define SAC_ST_LEAD 4
`define SAC_ST_NEXT_CH 5
`define SAC_DIV_W 10
`define SAC_DIV_RST 10'h032

`endif

/* File: sac_pkg.sv */
// Shared types for the serial converter host controller
`include "sac_regs.svh"
package sac_pkg;
	typedef enum logic [8:0] {
		st_idle = 9'h001,
		st_tog_lo = 9'h002,
		st_tog_hi = 9'h004,
		st_setup = 9'h008,
		st_wake = 9'h010,
		st_conv = 9'h020,
		st_shift = 9'h040,
		st_gap = 9'h080,
		st_hold = 9'h100
	} sac_state_t;
	typedef logic [`SAC_FRAME_BITS-1:0] sac_frame_t;
endpackage : sac_pkg

/* File: sac_link_if.sv */
// Signals between the sequencer, the clock divider and the shifter
`timescale 1ns/100ps
`include "sac_regs.svh"
interface sac_link_if import sac_pkg::*; ();
	logic run;
	logic [`SAC_DIV_W-1:0] half;
	logic tick;
	logic cap;
	logic clr;
	logic bit_in;
	sac_frame_t frame;
	logic [`SAC_CNT_W-1:0] count;
	modport tick_mp (input run, input half, output tick);
	modport shf_mp (input cap, input clr, input bit_in, output frame, output count);
endinterface : sac_link_if

/* File: sac_tick.sv */
// Half-period tick generator for the serial clock
`timescale 1ns/100ps
`include "sac_regs.svh"
module sac_tick import sac_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	sac_link_if.tick_mp lk
);
	logic [`SAC_DIV_W-1:0] cnt;

	// Count half periods while running
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt <= '0;
			lk.tick <= 1'b0;
		end else if (!lk.run) begin
			cnt <= '0;
			lk.tick <= 1'b0;
		end else if (cnt >= lk.half - 1'b1) begin
			cnt <= '0;
			lk.tick <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
			lk.tick <= 1'b0;
		end
	end

	tick_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		lk.tick |=> !lk.tick) else $error("tick longer than one cycle");
endmodule : sac_tick

/* File: sac_shift.sv */
// Capture shifter for the incoming result frame
`timescale 1ns/100ps
`include "sac_regs.svh"
module sac_shift import sac_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	sac_link_if.shf_mp lk
);
	// Shift in one bit per capture, MSB first
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lk.frame <= '0;
			lk.count <= '0;
		end else if (lk.clr) begin
			lk.frame <= '0;
			lk.count <= '0;
		end else if (lk.cap) begin
			lk.frame <= {lk.frame[`SAC_FRAME_BITS-2:0], lk.bit_in};
			lk.count <= lk.count + 1'b1;
		end
	end

	count_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		lk.cap && !lk.clr |=> lk.count == $past(lk.count) + 5'h01) else $error("bit count did not step");
endmodule : sac_shift

/* File: sac_host.sv */
// Host sequencer that runs conversions on a serial converter
`timescale 1ns/100ps
`include "sac_regs.svh"
// How it works
// - Clocks below 100kHz or above 2.17MHz must use internal mode.
// - External conversion must finish within 140us; the watchdog only flags tmo and does not stop the readout.
// - Device changes data on falling clock; host captures on rising.
// - Host waits 2.5us wake-up after select falls before clocking.
// - External mode: select falls with clock low, then 16 or more clocks.
// - Select rises no earlier than the 16th falling edge.
// - Select stays high at least 60ns between conversions.
// - Raising select early aborts; minimum high time still applies.
// - Clock idles low, data captured on rising edge.
// - Two-byte reads: lead ones, channel, top four bits; then the rest.
// - External mode clock stays between 100kHz and 2.17MHz; the byte gap adds 9 low cycles, under 100kHz at half periods of 996 up.
// - An extra select toggle repeats the same channel.
module sac_host import sac_pkg::*; #(
	parameter int CONV_CYC = `SAC_FLOOR_CYC(`SAC_CONV_MAX_NS),
	parameter bit PSEUDO_DIFF = 1'b0
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_dout,
	output logic o_sclk,
	output logic o_select_shutdown_n
);
	localparam int WAKE_CYC = `SAC_CEIL_CYC(`SAC_WAKE_NS);
	localparam int TCS_CYC = `SAC_CEIL_CYC(`SAC_TCS_NS);
	localparam int HALF_EXT_MIN = `SAC_HALF_CEIL(`SAC_EXT_FMAX_KHZ);
	localparam int HALF_EXT_MAX = `SAC_HALF_FLOOR(`SAC_EXT_FMIN_KHZ);
	localparam int HALF_INT_MIN = `SAC_HALF_CEIL(`SAC_INT_FMAX_KHZ);
	localparam int TW = $clog2(CONV_CYC + WAKE_CYC + 1);

	sac_state_t state;
	logic [TW-1:0] timer;
	logic [TW-1:0] wdog;
	logic [TW-1:0] lo_cnt;
	logic [TW-1:0] hi_cnt;
	logic [TW-1:0] edge_cnt;
	logic dout_m;
	logic dout_s;
	logic run;
	logic cap;
	logic clr;
	logic cur_int;
	logic byte_mode;
	logic gap_done;
	logic done_set;
	logic tmo_set;
	logic ch_next;
	logic ch_cur;
	logic [`SAC_DIV_W-1:0] div;
	logic [1:0] ctrl_mode;
	sac_frame_t result;
	logic done;
	logic tmo;
	logic mism;
	logic lead_bad;
	logic start;
	logic abort;
	logic [31:0] rd_mux;

	// Clamp the programmed half period to the legal range of the mode
	function automatic logic [`SAC_DIV_W-1:0] half_for(input logic internal, input logic [`SAC_DIV_W-1:0] d);
		logic [`SAC_DIV_W-1:0] h;
		h = d;
		if (internal) begin
			if (h < `SAC_DIV_W'(HALF_INT_MIN)) h = `SAC_DIV_W'(HALF_INT_MIN);
		end else begin
			if (h < `SAC_DIV_W'(HALF_EXT_MIN)) h = `SAC_DIV_W'(HALF_EXT_MIN);
			if (h > `SAC_DIV_W'(HALF_EXT_MAX)) h = `SAC_DIV_W'(HALF_EXT_MAX);
		end
		return h;
	endfunction : half_for

	sac_link_if lk ();

	sac_tick u_tick (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.lk(lk.tick_mp)
	);

	sac_shift u_shift (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.lk(lk.shf_mp)
	);

	// Link hookup and command decode
	assign lk.run = run;
	assign lk.half = half_for(cur_int, div);
	assign lk.cap = cap;
	assign lk.clr = clr;
	assign lk.bit_in = dout_s;
	assign start = i_wr && (i_addr == `SAC_ADDR_CTRL) && i_wdata[`SAC_CTRL_START];
	assign abort = i_wr && (i_addr == `SAC_ADDR_CTRL) && i_wdata[`SAC_CTRL_ABORT];

	// Two-stage synchroniser for the data pin
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dout_m <= 1'b0;
			dout_s <= 1'b0;
		end else begin
			dout_m <= i_dout;
			dout_s <= dout_m;
		end
	end

	// Conversion sequencer driving select and serial clock
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= st_idle;
			o_sclk <= 1'b0;
			o_select_shutdown_n <= 1'b1;
			timer <= '0;
			run <= 1'b0;
			cap <= 1'b0;
			clr <= 1'b0;
			cur_int <= 1'b0;
			byte_mode <= 1'b0;
			gap_done <= 1'b0;
			done_set <= 1'b0;
			tmo_set <= 1'b0;
			ch_next <= 1'b0;
			ch_cur <= 1'b0;
		end else begin
			cap <= 1'b0;
			clr <= 1'b0;
			done_set <= 1'b0;
			tmo_set <= 1'b0;
			if (timer != '0) timer <= timer - 1'b1;
			if (abort && state != st_idle && state != st_hold) begin
				// Early deselect drops the frame, then minimum high time
				o_select_shutdown_n <= 1'b1;
				o_sclk <= 1'b0;
				run <= 1'b0;
				timer <= TW'(TCS_CYC - 1);
				state <= st_hold;
			end else begin
				case (state)
					st_idle: begin
						if (start) begin
							cur_int <= i_wdata[`SAC_CTRL_INT];
							byte_mode <= i_wdata[`SAC_CTRL_BYTE];
							gap_done <= 1'b0;
							clr <= 1'b1;
							if (i_wdata[`SAC_CTRL_REPEAT]) begin
								o_select_shutdown_n <= 1'b0;
								ch_next <= ~ch_next;
								timer <= TW'(TCS_CYC - 1);
								state <= st_tog_lo;
							end else begin
								o_sclk <= i_wdata[`SAC_CTRL_INT];
								state <= st_setup;
							end
						end
					end
					st_tog_lo: begin
						if (timer == '0) begin
							o_select_shutdown_n <= 1'b1;
							timer <= TW'(TCS_CYC - 1);
							state <= st_tog_hi;
						end
					end
					st_tog_hi: begin
						if (timer == '0) begin
							o_sclk <= cur_int;
							state <= st_setup;
						end
					end
					st_setup: begin
						// Clock level is settled; lower select to wake and sample
						o_select_shutdown_n <= 1'b0;
						ch_cur <= ch_next;
						ch_next <= ~ch_next;
						timer <= TW'(WAKE_CYC - 1);
						state <= st_wake;
					end
					st_wake: begin
						if (timer == '0) begin
							if (cur_int) begin
								o_sclk <= 1'b0;
								timer <= TW'(CONV_CYC - 1);
								state <= st_conv;
							end else begin
								run <= 1'b1;
								state <= st_shift;
							end
						end
					end
					st_conv: begin
						if (dout_s) begin
							run <= 1'b1;
							state <= st_shift;
						end else if (timer == '0) begin
							tmo_set <= 1'b1;
							o_select_shutdown_n <= 1'b1;
							timer <= TW'(TCS_CYC - 1);
							state <= st_hold;
						end
					end
					st_shift: begin
						if (lk.tick) begin
							if (!o_sclk) begin
								o_sclk <= 1'b1;
								cap <= 1'b1;
							end else begin
								o_sclk <= 1'b0;
								if (lk.count == `SAC_CNT_W'(`SAC_FRAME_BITS)) begin
									// Stop at the 16th falling edge; no trailing zeros read
									run <= 1'b0;
									o_select_shutdown_n <= 1'b1;
									done_set <= 1'b1;
									timer <= TW'(TCS_CYC - 1);
									state <= st_hold;
								end else if (byte_mode && !gap_done &&
									lk.count == `SAC_CNT_W'(`SAC_BYTE_BITS)) begin
									run <= 1'b0;
									gap_done <= 1'b1;
									timer <= TW'(`SAC_BYTE_GAP_CYC - 1);
									state <= st_gap;
								end
							end
						end
					end
					st_gap: begin
						if (timer == '0) begin
							run <= 1'b1;
							state <= st_shift;
						end
					end
					st_hold: begin
						if (timer == '0) state <= st_idle;
					end
					default: begin
						state <= st_idle;
						o_select_shutdown_n <= 1'b1;
						o_sclk <= 1'b0;
						run <= 1'b0;
					end
				endcase
			end
		end
	end

	// Conversion watchdog for external mode
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wdog <= '0;
		end else if ((state == st_shift || state == st_gap) && !cur_int) begin
			if (wdog != TW'(CONV_CYC)) wdog <= wdog + 1'b1;
		end else begin
			wdog <= '0;
		end
	end

	// Timing counters on the pins
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lo_cnt <= '0;
			hi_cnt <= TW'(TCS_CYC);
			edge_cnt <= '0;
		end else begin
			lo_cnt <= o_select_shutdown_n ? '0 : (lo_cnt == '1 ? lo_cnt : lo_cnt + 1'b1);
			hi_cnt <= !o_select_shutdown_n ? '0 : (hi_cnt == '1 ? hi_cnt : hi_cnt + 1'b1);
			edge_cnt <= (o_sclk != $past(o_sclk)) ? '0 : (edge_cnt == '1 ? edge_cnt : edge_cnt + 1'b1);
		end
	end

	// Software registers and sticky status, set wins over clear
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div <= `SAC_DIV_RST;
			ctrl_mode <= '0;
			result <= '0;
			done <= 1'b0;
			tmo <= 1'b0;
			mism <= 1'b0;
			lead_bad <= 1'b0;
		end else begin
			if (i_wr && i_addr == `SAC_ADDR_DIV) div <= i_wdata[`SAC_DIV_W-1:0];
			if (i_wr && i_addr == `SAC_ADDR_CTRL) ctrl_mode <= i_wdata[`SAC_CTRL_BYTE:`SAC_CTRL_INT];
			if (done_set) begin
				result <= lk.frame;
				done <= 1'b1;
				mism <= lk.frame[`SAC_CHANNEL_ID_BIT_POS] != (PSEUDO_DIFF | ch_cur);
				lead_bad <= lk.frame[`SAC_LEAD_MSB:`SAC_LEAD_LSB] != `SAC_LEAD_ONES;
			end else if (i_wr && i_addr == `SAC_ADDR_STATUS && i_wdata[`SAC_ST_DONE]) begin
				done <= 1'b0;
				mism <= 1'b0;
				lead_bad <= 1'b0;
			end
			if (tmo_set || wdog == TW'(CONV_CYC - 1)) tmo <= 1'b1;
			else if (i_wr && i_addr == `SAC_ADDR_STATUS && i_wdata[`SAC_ST_TMO]) tmo <= 1'b0;
		end
	end

	// Read mux
	always_comb begin
		rd_mux = '0;
		case (i_addr)
			`SAC_ADDR_CTRL: rd_mux[`SAC_CTRL_BYTE:`SAC_CTRL_INT] = ctrl_mode;
			`SAC_ADDR_STATUS: begin
				rd_mux[`SAC_ST_BUSY] = state != st_idle;
				rd_mux[`SAC_ST_DONE] = done;
				rd_mux[`SAC_ST_TMO] = tmo;
				rd_mux[`SAC_ST_MISM] = mism;
				rd_mux[`SAC_ST_LEAD] = lead_bad;
				rd_mux[`SAC_ST_NEXT_CH] = ch_next;
			end
			`SAC_ADDR_RESULT: rd_mux[`SAC_FRAME_BITS-1:0] = result;
			`SAC_ADDR_DIV: rd_mux[`SAC_DIV_W-1:0] = div;
			default: rd_mux = '0;
		endcase
	end

	// Read data for one cycle after the strobe
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) o_rdata <= '0;
		else o_rdata <= i_rd ? rd_mux : '0;
	end

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);

	ext_fall_low_a: assert property ($fell(o_select_shutdown_n) && state == st_wake && !cur_int |-> !o_sclk)
		else $error("external select fell with clock high");
	int_fall_high_a: assert property ($fell(o_select_shutdown_n) && state == st_wake && cur_int |-> o_sclk)
		else $error("internal select fell with clock low");
	wake_delay_a: assert property ($changed(o_sclk) && !o_select_shutdown_n |-> lo_cnt >= TW'(WAKE_CYC))
		else $error("clock moved before wake-up time");
	cs_high_time_a: assert property ($fell(o_select_shutdown_n) |-> $past(hi_cnt) >= TW'(TCS_CYC))
		else $error("select high time too short");
	half_period_a: assert property ($changed(o_sclk) && state == st_shift && !cur_int
		|-> edge_cnt >= TW'(HALF_EXT_MIN - 1))
		else $error("external clock too fast");
	capture_rise_a: assert property (cap |-> $rose(o_sclk))
		else $error("capture not on rising clock");
	full_frame_a: assert property (done_set |-> $past(lk.count) == `SAC_CNT_W'(`SAC_FRAME_BITS) && o_select_shutdown_n)
		else $error("select rose before full frame");
	idle_polarity_a: assert property (state == st_idle |-> !o_sclk && o_select_shutdown_n)
		else $error("idle clock not low");
	eoc_seen_a: assert property (state == st_shift && $past(state) == st_conv |-> $past(dout_s))
		else $error("readout began before end of conversion");
	byte_gap_a: assert property (state == st_gap |-> lk.count == `SAC_CNT_W'(`SAC_BYTE_BITS) && !o_sclk)
		else $error("byte gap at wrong place");

	ext_done_c: cover property (done_set && !cur_int);
	int_done_c: cover property (done_set && cur_int);
	repeat_toggle_c: cover property (state == st_tog_hi);
	abort_c: cover property (abort && state == st_shift);
endmodule : sac_host

/* File: sac_adc_model.sv */
// Pin-level model of the two-channel serial converter
`timescale 1ns/100ps
module sac_adc_model import sac_pkg::*; #(
	parameter int CONV_CYC = 1100
) (
	input wire logic i_clk,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_stall,
	input wire logic [9:0] i_res0,
	input wire logic [9:0] i_res1,
	input wire logic [1:0] i_sub,
	output logic o_oe,
	output logic o_d,
	output logic o_viol
);
	logic int_mode = 1'b0;
	logic wait_start = 1'b0;
	logic conv = 1'b0;
	logic ch_next = 1'b0;
	sac_frame_t frame = 16'h0;
	int cnt = 0;
	int conv_cnt = 0;
	realtime t_fall = 0.0;
	realtime t_rise_cs = 0.0;
	realtime t_rise = 0.0;
	// Line released, no host faults seen
	initial begin
		o_oe = 1'b0;
		o_d = 1'b0;
		o_viol = 1'b0;
	end
	// Select falling wakes the part, picks the mode and loads the frame
	always @(negedge i_cs_n) begin
		if ($realtime - t_rise_cs < 60.0) o_viol = 1'b1;
		t_fall = $realtime;
		int_mode = i_sclk;
		frame = {3'h7, ch_next, ch_next ? i_res1 : i_res0, i_sub};
		ch_next = ~ch_next;
		cnt = 0;
		wait_start = int_mode;
		conv = 1'b0;
		o_oe = 1'b1;
		o_d = int_mode ? 1'b0 : frame[15];
	end
	// Deselect floats the line and drops any frame or conversion
	always @(posedge i_cs_n) begin
		if (!int_mode && $realtime - t_fall > 140000.0) o_viol = 1'b1;
		t_rise_cs = $realtime;
		o_oe = 1'b0;
		conv = 1'b0;
		wait_start = 1'b0;
	end
	// Falling clock starts an internal conversion or moves to the next bit
	always @(negedge i_sclk) if (i_cs_n === 1'b0) begin
		if ($realtime - t_fall < 2500.0) o_viol = 1'b1;
		if (wait_start) begin
			wait_start = 1'b0;
			conv = 1'b1;
			conv_cnt = 0;
		end else if (!conv) begin
			cnt++;
			o_d = (cnt < 16) ? frame[15 - cnt] : 1'b0;
		end
	end
	// Rising clock while selected: wake-up wait and external rate window
	always @(posedge i_sclk) if (i_cs_n === 1'b0) begin
		if ($realtime - t_fall < 2500.0) o_viol = 1'b1;
		if (!int_mode && t_rise > t_fall) begin
			if ($realtime - t_rise < 460.8 || $realtime - t_rise > 10000.0) o_viol = 1'b1;
		end
		t_rise = $realtime;
	end
	// Oscillator steps the conversion; its end raises the line
	always @(posedge i_clk) if (conv && !i_stall) begin
		conv_cnt++;
		if (conv_cnt >= CONV_CYC) begin
			conv = 1'b0;
			o_d <= 1'b1;
		end
	end
endmodule : sac_adc_model

/* File: sac_host_bench.sv */
// Self-checking bench for the serial converter host controller
`timescale 1ns/100ps
module sac_host_bench import sac_pkg::*; ();
	localparam logic [9:0] RES0 = 10'h2a5;
	localparam logic [9:0] RES1 = 10'h15a;
	localparam logic [1:0] SUB = 2'h2;
	logic i_clk_sys = 1'b0;
	logic i_rst_b = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic o_sclk, o_select_shutdown_n, dout_oe, dout_d, viol;
	logic stall = 1'b0;
	logic exp_ch = 1'b0;
	wire logic i_dout;
	sac_frame_t exp_fr;
	sac_frame_t last_fr = 16'h0;
	int fails = 0;
	int cmp_count = 0;
	int cycles = 0;
	// Clock and released-line level (inverse of last driven bit)
	always #2.5 i_clk_sys = ~i_clk_sys;
	assign i_dout = dout_oe ? dout_d : ~dout_d;
	sac_host #(.CONV_CYC(2000), .PSEUDO_DIFF(1'b0)) sac_host_inst (
		.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_dout(i_dout), .o_sclk(o_sclk),
		.o_select_shutdown_n(o_select_shutdown_n));
	sac_adc_model sac_adc_model_inst (
		.i_clk(i_clk_sys), .i_sclk(o_sclk), .i_cs_n(o_select_shutdown_n), .i_stall(stall),
		.i_res0(RES0), .i_res1(RES1), .i_sub(SUB), .o_oe(dout_oe), .o_d(dout_d), .o_viol(viol));
	task automatic stop_test();
		if (fails == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		chk(d, exp);
		@(posedge i_clk_sys);
		#1 chk(o_rdata, 32'h0);
	endtask : rd_chk
	// One conversion: divider, start, optional abort, wait, then status and frame
	task automatic run(input logic [31:0] ctrl, input logic [31:0] div, input logic [31:0] kind);
		logic [31:0] st;
		int n;
		wr(8'h0c, div);
		if (ctrl[3]) exp_ch = ~exp_ch; // Extra toggle uses up one channel
		exp_fr = {3'h7, exp_ch, exp_ch ? RES1 : RES0, SUB};
		exp_ch = ~exp_ch;
		wr(8'h00, (ctrl & 32'hf) | 32'h1);
		if (ctrl[4]) begin
			repeat (5) @(posedge o_sclk);
			wr(8'h00, 32'h10);
		end
		st = 32'h1;
		for (n = 0; n < 3000 && st[0] !== 1'b0; n++) begin
			rd(8'h04, st);
		end
		repeat (16) @(posedge i_clk_sys);
		chk(st, {26'h0, exp_ch, 5'h0} | kind);
		if (kind == 32'h2) last_fr = exp_fr;
		rd_chk(8'h08, {16'h0, last_fr});
		wr(8'h04, 32'h6);
	endtask : run
	// Hang guard
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			stop_test();
		end
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		rd_chk(8'h00, 32'h0);
		rd_chk(8'h04, 32'h0);
		rd_chk(8'h08, 32'h0);
		rd_chk(8'h0c, 32'h32);
		wr(8'h10, 32'h6);
		rd_chk(8'h10, 32'h0);
		rd_chk(8'h00, 32'h0);
		wr(8'h00, 32'h6);
		rd_chk(8'h00, 32'h6);
		run(32'h0, 32'h32, 32'h2);
		run(32'h4, 32'h1, 32'h2);
		run(32'h2, 32'h5, 32'h2);
		run(32'h8, 32'h32, 32'h2);
		run(32'h10, 32'h32, 32'h0);
		run(32'h0, 32'h32, 32'h2);
		stall <= 1'b1;
		run(32'h2, 32'h32, 32'h4);
		stall <= 1'b0;
		run(32'h6, 32'h32, 32'h2);
		chk({31'h0, viol}, 32'h0);
		stop_test();
	end
endmodule : sac_host_bench
